// ===== rtl/flash_if_core.sv
// Interface state sequencing for a multi-I/O serial flash port.
// Summary of operation
// R01: Chip select high means standby; falling chip select starts instruction.
// R02: Instruction is eight bits, MSB first, one per rising clock edge.
// R03: Write-protect is sampled only during a status-write instruction.
// R04: Instruction selects address space, transfer format and next state.
// R05: Host raises chip select after bit eight of a lone instruction.
// R06: Without quad enable, IO3 acts as an active-low pause input.
// R07: Pause with chip select low freezes progress despite clock toggling.
// R08: During pause IO0/IO1 inputs are ignored and outputs float.
// R09: Leaving pause resumes the exact state held before it.
// R10: Single input cycles use only serial input; serial output floats.
// R11: After single input: more input, single latency, or any output.
// R12: Latency cycles ignore data lines and drive nothing.
// R13: Host releases I/O lines by the end of the last latency cycle.
// R14: Single output drives serial output until chip select rises.
// R15: Dual I/O address and mode arrive two bits per clock.
// R16: Dual I/O goes to dual latency if needed, else dual output.
// R17: Write commands are rejected until the power-up write delay ends.
// R18: In dual and quad groups the lowest bit sits on IO0.
// R19: Quad enable disables pause and write-protect, permits quad reads.
// R20: Quad read latency comes from the four-bit latency field.
// R21: Chip select rising aborts, clears counters, returns to standby.
// R22: Drivers are enabled only on lines an output state assigns.
`timescale 1ns/1ps
module flash_if_core
	import flash_if_pkg::*;
#(
	parameter int unsigned PUW_CYCLES = POWER_UP_WRITE_DELAY_US * CLK_MHZ,
	parameter int unsigned SINGLE_LATENCY = 8,
	parameter int unsigned DUAL_IO_LATENCY = 0,
	parameter int unsigned FIFO_DEPTH = 32
) (
	// Clock, reset and clock enable.
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Flash port pins.
	input wire logic cs_n_pin,
	input wire logic sck_pin,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe_n,
	// Status register fields.
	input wire logic quad_enable_bit,
	input wire logic [3:0] quad_latency_field,
	// Read data source.
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	output logic rd_ready,
	// Decoded command results.
	output logic [7:0] cmd_code,
	output logic cmd_strobe,
	output logic cmd_reject,
	output logic [23:0] addr,
	output logic addr_strobe,
	output logic [7:0] mode_bits,
	output logic [7:0] wr_byte,
	output logic wr_strobe,
	output logic wsr_protect,
	output logic write_ready,
	output logic paused
);

	localparam int unsigned PUW_W = $clog2(PUW_CYCLES + 1);

	logic [5:0] pin_s;
	logic cs_s;
	logic sck_s;
	logic [3:0] io_s;
	logic sck_prev_ff;
	logic cs_prev_ff;
	logic hold_now;
	logic rise;
	logic fall;
	logic cs_fall;
	state_type state_ff;
	state_type nxt_state;
	fmt_type fmt_ff;
	fmt_type nxt_fmt;
	fmt_type fmt_now;
	logic [CNT_W-1:0] bit_cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic data_phase_ff;
	logic nxt_phase;
	logic [31:0] in_sr_ff;
	logic [31:0] nxt_sr;
	logic [7:0] op_now;
	logic reject_now;
	logic instr_done;
	logic wsr_done;
	logic addr_done;
	logic byte_done;
	logic [PUW_W-1:0] pu_cnt_ff;
	logic write_ready_ff;
	logic [7:0] cmd_code_ff;
	logic cmd_strobe_ff;
	logic cmd_reject_ff;
	logic [23:0] addr_ff;
	logic addr_strobe_ff;
	logic [7:0] mode_bits_ff;
	logic [7:0] wr_byte_ff;
	logic wr_strobe_ff;
	logic wsr_protect_ff;
	logic paused_ff;
	logic [3:0] io_out_ff;
	logic [3:0] io_oe_n_ff;
	logic [7:0] out_sr_ff;
	logic [2:0] out_left_ff;
	logic out_started_ff;
	logic [7:0] cur_byte;
	logic [7:0] fifo_data;
	logic fifo_valid;
	logic fifo_pop;

	function automatic logic is_out(input state_type st);
		is_out = (st == ST_SOUT) || (st == ST_DOUT) || (st == ST_QOUT);
	endfunction

	function automatic logic [3:0] lane_mask(input state_type st);
		case (st)
			ST_SOUT: lane_mask = LANES_SINGLE;
			ST_DOUT: lane_mask = LANES_DUAL;
			ST_QOUT: lane_mask = LANES_QUAD;
			default: lane_mask = 4'h0;
		endcase
	endfunction

	function automatic logic [CNT_W-1:0] lat_cycles(input fmt_type fmt);
		case (fmt)
			FMT_FAST, FMT_DUAL_OUT: lat_cycles = CNT_W'(SINGLE_LATENCY);
			FMT_DUAL_IO: lat_cycles = CNT_W'(DUAL_IO_LATENCY);
			FMT_QUAD_OUT, FMT_QUAD_IO: lat_cycles = {2'b00, quad_latency_field};
			default: lat_cycles = '0;
		endcase
	endfunction

	function automatic state_type out_state(input fmt_type fmt);
		case (fmt)
			FMT_DUAL_OUT, FMT_DUAL_IO: out_state = ST_DOUT;
			FMT_QUAD_OUT, FMT_QUAD_IO: out_state = ST_QOUT;
			default: out_state = ST_SOUT;
		endcase
	endfunction

	function automatic state_type after_addr(input fmt_type fmt);
		if (lat_cycles(fmt) == '0) begin
			after_addr = out_state(fmt);
		end else if (fmt == FMT_DUAL_IO) begin
			after_addr = ST_DLAT;
		end else if (fmt == FMT_QUAD_IO) begin
			after_addr = ST_QLAT;
		end else begin
			after_addr = ST_SLAT;
		end
	endfunction

	function automatic state_type after_instr(input fmt_type fmt);
		case (fmt)
			FMT_NONE: after_instr = ST_STANDBY;
			FMT_DUAL_IO: after_instr = ST_DIN;
			FMT_QUAD_IO: after_instr = ST_QIN;
			default: after_instr = ST_SIN;
		endcase
	endfunction

	flash_if_sync #(
		.WIDTH(6),
		.RESET_VAL(PIN_RESET)
	) u_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.d({cs_n_pin, sck_pin, io_in}),
		.q(pin_s)
	);

	flash_if_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.in_data(rd_data),
		.in_valid(rd_valid),
		.in_ready(rd_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	assign cs_s = pin_s[5];
	assign sck_s = pin_s[4];
	assign io_s = pin_s[3:0];

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sck_prev_ff <= 1'b1;
			cs_prev_ff <= 1'b1;
		end else if (clk_en) begin
			sck_prev_ff <= sck_s;
			cs_prev_ff <= cs_s;
		end
	end

	// Pause is recognised only when quad mode leaves IO3 as an input.
	assign hold_now = !quad_enable_bit && !io_s[3] && !cs_s &&
		(state_ff != ST_STANDBY); // see R06 see R19
	// Clock edges are discarded while paused, as if the clock had stopped.
	assign rise = clk_en && sck_s && !sck_prev_ff && !cs_s &&
		!hold_now; // see R07
	assign fall = clk_en && !sck_s && sck_prev_ff && !cs_s && !hold_now;
	assign cs_fall = clk_en && cs_prev_ff && !cs_s;

	assign op_now = {in_sr_ff[6:0], io_s[0]}; // see R02
	assign fmt_now = decode_op(op_now);
	assign reject_now = (is_write_op(op_now) && !write_ready_ff) ||
		(is_quad_fmt(fmt_now) && !quad_enable_bit); // see R17 see R19
	assign instr_done = rise && (state_ff == ST_INSTR) &&
		(bit_cnt_ff == INSTR_END);
	assign wsr_done = instr_done && (fmt_now == FMT_WSR) && !reject_now;
	assign addr_done = rise && (((state_ff == ST_SIN) && !data_phase_ff &&
		(bit_cnt_ff == ADDR_END)) ||
		((state_ff == ST_DIN) && (bit_cnt_ff == DUAL_END)) ||
		((state_ff == ST_QIN) && (bit_cnt_ff == QUAD_END)));
	assign byte_done = rise && (state_ff == ST_SIN) && data_phase_ff &&
		(bit_cnt_ff == BYTE_END);

	// Higher-numbered lines carry the more significant bits of a group.
	always_comb begin
		unique case (state_ff)
			ST_DIN: nxt_sr = {in_sr_ff[29:0], io_s[1:0]}; // see R15 see R18
			ST_QIN: nxt_sr = {in_sr_ff[27:0], io_s}; // see R18
			default: nxt_sr = {in_sr_ff[30:0], io_s[0]}; // see R10
		endcase
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = bit_cnt_ff + CNT_W'(1);
		nxt_fmt = fmt_ff;
		nxt_phase = data_phase_ff;
		unique case (state_ff)
			ST_STANDBY: nxt_cnt = bit_cnt_ff;
			ST_INSTR: begin
				if (bit_cnt_ff == INSTR_END) begin
					nxt_cnt = '0;
					nxt_fmt = reject_now ? FMT_NONE : fmt_now; // see R04
					nxt_phase = (fmt_now == FMT_WSR);
					// A lone instruction waits in standby for chip select.
					nxt_state = after_instr(nxt_fmt); // see R04 see R05
				end
			end
			ST_SIN: begin
				if (data_phase_ff) begin
					if (bit_cnt_ff == BYTE_END) begin
						nxt_cnt = '0;
					end
				end else if (bit_cnt_ff == ADDR_END) begin
					nxt_cnt = '0;
					if (fmt_ff == FMT_PROGRAM) begin
						nxt_phase = 1'b1;
					end else begin
						nxt_state = after_addr(fmt_ff); // see R11
					end
				end
			end
			ST_DIN: begin
				if (bit_cnt_ff == DUAL_END) begin
					nxt_cnt = '0;
					nxt_state = after_addr(fmt_ff); // see R16
				end
			end
			ST_QIN: begin
				if (bit_cnt_ff == QUAD_END) begin
					nxt_cnt = '0;
					nxt_state = after_addr(fmt_ff); // see R20
				end
			end
			// Latency cycles only count clocks; data lines are not read.
			ST_SLAT, ST_DLAT, ST_QLAT: begin
				if (bit_cnt_ff == lat_cycles(fmt_ff) - CNT_W'(1)) begin
					nxt_cnt = '0;
					nxt_state = out_state(fmt_ff); // see R12 see R20
				end
			end
			ST_SOUT, ST_DOUT, ST_QOUT: nxt_cnt = bit_cnt_ff; // see R14
		endcase
	end

	// Without a qualifying edge the state simply holds, so a pause resumes.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= ST_STANDBY;
			fmt_ff <= FMT_NONE;
			bit_cnt_ff <= '0;
			data_phase_ff <= 1'b0;
			in_sr_ff <= '0;
		end else if (clk_en) begin
			if (cs_s) begin
				state_ff <= ST_STANDBY; // see R01 see R21
				bit_cnt_ff <= '0;
				data_phase_ff <= 1'b0;
			end else if (cs_fall) begin
				state_ff <= ST_INSTR; // see R01
				bit_cnt_ff <= '0;
				data_phase_ff <= 1'b0;
			end else if (rise) begin // see R09
				state_ff <= nxt_state;
				fmt_ff <= nxt_fmt;
				bit_cnt_ff <= nxt_cnt;
				data_phase_ff <= nxt_phase;
				in_sr_ff <= nxt_sr;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pu_cnt_ff <= '0;
			write_ready_ff <= 1'b0;
		end else if (clk_en && !write_ready_ff) begin
			pu_cnt_ff <= pu_cnt_ff + PUW_W'(1);
			if (pu_cnt_ff == PUW_W'(PUW_CYCLES - 1)) begin
				write_ready_ff <= 1'b1; // see R17
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cmd_code_ff <= '0;
			cmd_strobe_ff <= 1'b0;
			cmd_reject_ff <= 1'b0;
			wsr_protect_ff <= 1'b0;
		end else if (clk_en) begin
			cmd_strobe_ff <= instr_done && !reject_now;
			cmd_reject_ff <= instr_done && reject_now; // see R17
			if (instr_done) begin
				cmd_code_ff <= op_now;
			end
			if (wsr_done) begin
				wsr_protect_ff <= !quad_enable_bit && !io_s[2]; // see R03
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			addr_ff <= '0;
			mode_bits_ff <= '0;
			addr_strobe_ff <= 1'b0;
			wr_byte_ff <= '0;
			wr_strobe_ff <= 1'b0;
			paused_ff <= 1'b0;
		end else if (clk_en) begin
			addr_strobe_ff <= addr_done;
			wr_strobe_ff <= byte_done;
			paused_ff <= hold_now;
			if (addr_done && (state_ff == ST_SIN)) begin
				addr_ff <= nxt_sr[23:0];
			end else if (addr_done) begin
				addr_ff <= nxt_sr[31:8]; // see R15
				mode_bits_ff <= nxt_sr[7:0];
			end
			if (byte_done) begin
				wr_byte_ff <= nxt_sr[7:0];
			end
		end
	end

	// A byte starts from the FIFO; an empty FIFO sends zeros.
	assign cur_byte = (out_left_ff != '0) ? out_sr_ff :
		(fifo_valid ? fifo_data : 8'h00);
	assign fifo_pop = fall && is_out(state_ff) && (out_left_ff == '0) &&
		fifo_valid;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			io_out_ff <= 4'h0;
			io_oe_n_ff <= OE_OFF;
			out_sr_ff <= '0;
			out_left_ff <= '0;
			out_started_ff <= 1'b0;
		end else if (clk_en) begin
			if (!is_out(state_ff) || cs_s) begin
				io_oe_n_ff <= OE_OFF; // see R12 see R22
				out_left_ff <= '0;
				out_started_ff <= 1'b0;
			end else if (hold_now) begin
				io_oe_n_ff <= OE_OFF; // see R08
			end else if (fall) begin
				io_oe_n_ff <= ~lane_mask(state_ff); // see R22
				out_started_ff <= 1'b1;
				unique case (state_ff)
					ST_DOUT: begin
						io_out_ff <= {2'b00, cur_byte[7:6]}; // see R18
						out_sr_ff <= {cur_byte[5:0], 2'b00};
						out_left_ff <= (out_left_ff == '0) ? 3'h3 : out_left_ff - 3'h1;
					end
					ST_QOUT: begin
						io_out_ff <= cur_byte[7:4]; // see R18
						out_sr_ff <= {cur_byte[3:0], 4'h0};
						out_left_ff <= (out_left_ff == '0) ? 3'h1 : out_left_ff - 3'h1;
					end
					default: begin
						io_out_ff <= {2'b00, cur_byte[7], 1'b0}; // see R14
						out_sr_ff <= {cur_byte[6:0], 1'b0};
						out_left_ff <= (out_left_ff == '0) ? 3'h7 : out_left_ff - 3'h1;
					end
				endcase
			end else if (out_started_ff) begin
				io_oe_n_ff <= ~lane_mask(state_ff); // see R09
			end
		end
	end

	assign io_out = io_out_ff;
	assign io_oe_n = io_oe_n_ff;
	assign cmd_code = cmd_code_ff;
	assign cmd_strobe = cmd_strobe_ff;
	assign cmd_reject = cmd_reject_ff;
	assign addr = addr_ff;
	assign addr_strobe = addr_strobe_ff;
	assign mode_bits = mode_bits_ff;
	assign wr_byte = wr_byte_ff;
	assign wr_strobe = wr_strobe_ff;
	assign wsr_protect = wsr_protect_ff;
	assign write_ready = write_ready_ff;
	assign paused = paused_ff;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	a_cs_standby: // see R21
	assert property (clk_en && cs_s |=> state_ff == ST_STANDBY)
	else $error("Chip select high left the interface active.");

	a_idle_no_drive: // see R22
	assert property (clk_en && !is_out(state_ff) |=> io_oe_n_ff == OE_OFF)
	else $error("A driver was enabled outside an output state.");

	a_pause_freeze: // see R07
	assert property (clk_en && hold_now && !cs_s |=>
		$stable(state_ff) && $stable(bit_cnt_ff))
	else $error("Interface state moved during a pause.");

	a_pause_float: // see R08
	assert property (clk_en && hold_now |=> io_oe_n_ff[1:0] == 2'b11)
	else $error("IO0 or IO1 driven during a pause.");

	a_instr_length: // see R02
	assert property (instr_done |=> (cmd_strobe_ff || cmd_reject_ff) &&
		state_ff != ST_INSTR)
	else $error("Instruction did not end after eight bits.");

	a_write_gate: // see R17
	assert property (instr_done && is_write_op(op_now) && !write_ready_ff |=>
		cmd_reject_ff && !cmd_strobe_ff)
	else $error("Write command accepted before the power-up delay.");

	a_quad_gate: // see R19
	assert property (instr_done && is_quad_fmt(fmt_now) && !quad_enable_bit
		|=> cmd_reject_ff && state_ff == ST_STANDBY)
	else $error("Quad read accepted without quad enable.");

	a_single_lane: // see R14
	assert property (clk_en && state_ff == ST_SOUT |=>
		io_oe_n_ff[0] && io_oe_n_ff[3:2] == 2'b11)
	else $error("Single output drove a line other than IO1.");

	a_wp_only_wsr: // see R03
	assert property (clk_en && !wsr_done |=> $stable(wsr_protect_ff))
	else $error("Write-protect level taken outside a status write.");

	a_quad_latency: // see R20
	assert property (rise && state_ff == ST_QIN && bit_cnt_ff == QUAD_END
		|=> state_ff == ((quad_latency_field == 4'h0) ? ST_QOUT : ST_QLAT))
	else $error("Quad I/O did not follow the latency field.");

endmodule // flash_if_core

// ===== common/flash_if_pkg.sv
// Shared constants, types and decode helpers for the flash interface logic.
package flash_if_pkg;

	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned POWER_UP_WRITE_DELAY_US = 1000;

	localparam int unsigned CNT_W = 6;
	localparam int unsigned INSTR_BITS = 8;
	localparam int unsigned ADDR_BITS = 24;
	localparam int unsigned MODE_BITS = 8;
	localparam int unsigned BYTE_BITS = 8;
	localparam int unsigned DUAL_EDGES = (ADDR_BITS + MODE_BITS) / 2;
	localparam int unsigned QUAD_EDGES = (ADDR_BITS + MODE_BITS) / 4;
	localparam logic [CNT_W-1:0] INSTR_END = CNT_W'(INSTR_BITS - 1);
	localparam logic [CNT_W-1:0] ADDR_END = CNT_W'(ADDR_BITS - 1);
	localparam logic [CNT_W-1:0] BYTE_END = CNT_W'(BYTE_BITS - 1);
	localparam logic [CNT_W-1:0] DUAL_END = CNT_W'(DUAL_EDGES - 1);
	localparam logic [CNT_W-1:0] QUAD_END = CNT_W'(QUAD_EDGES - 1);

	localparam logic [3:0] OE_OFF = 4'hf;
	localparam logic [3:0] LANES_SINGLE = 4'h2;
	localparam logic [3:0] LANES_DUAL = 4'h3;
	localparam logic [3:0] LANES_QUAD = 4'hf;
	localparam logic [5:0] PIN_RESET = 6'h3f;

	localparam logic [7:0] OP_WSR = 8'h01;
	localparam logic [7:0] OP_PROGRAM = 8'h02;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_FAST = 8'h0b;
	localparam logic [7:0] OP_ERASE = 8'h20;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
	localparam logic [7:0] OP_DUAL_IO = 8'hbb;
	localparam logic [7:0] OP_QUAD_IO = 8'heb;

	typedef enum logic [10:0] {
		ST_STANDBY = 11'h001,
		ST_INSTR = 11'h002,
		ST_SIN = 11'h004,
		ST_SLAT = 11'h008,
		ST_SOUT = 11'h010,
		ST_DIN = 11'h020,
		ST_DLAT = 11'h040,
		ST_DOUT = 11'h080,
		ST_QIN = 11'h100,
		ST_QLAT = 11'h200,
		ST_QOUT = 11'h400
	} state_type;

	typedef enum logic [3:0] {
		FMT_NONE, FMT_READ, FMT_FAST, FMT_DUAL_OUT, FMT_QUAD_OUT,
		FMT_DUAL_IO, FMT_QUAD_IO, FMT_PROGRAM, FMT_WSR
	} fmt_type;

	function automatic fmt_type decode_op(input logic [7:0] op);
		case (op)
			OP_READ: decode_op = FMT_READ;
			OP_FAST: decode_op = FMT_FAST;
			OP_DUAL_OUT: decode_op = FMT_DUAL_OUT;
			OP_QUAD_OUT: decode_op = FMT_QUAD_OUT;
			OP_DUAL_IO: decode_op = FMT_DUAL_IO;
			OP_QUAD_IO: decode_op = FMT_QUAD_IO;
			OP_PROGRAM: decode_op = FMT_PROGRAM;
			OP_WSR: decode_op = FMT_WSR;
			default: decode_op = FMT_NONE;
		endcase
	endfunction

	function automatic logic is_write_op(input logic [7:0] op);
		is_write_op = (op == OP_WSR) || (op == OP_PROGRAM) ||
			(op == OP_WREN) || (op == OP_ERASE);
	endfunction

	function automatic logic is_quad_fmt(input fmt_type fmt);
		is_quad_fmt = (fmt == FMT_QUAD_OUT) || (fmt == FMT_QUAD_IO);
	endfunction

endpackage

// ===== rtl/flash_if_sync.sv
// Two-flop synchroniser for the pins of the flash port.
`timescale 1ns/1ps
module flash_if_sync #(
	parameter int unsigned WIDTH = 6,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	// Clock, reset and enable.
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Pin levels in and out.
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			meta_ff <= RESET_VAL;
			sync_ff <= RESET_VAL;
		end else if (clk_en) begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;

endmodule // flash_if_sync

// ===== rtl/flash_if_fifo.sv
// Flip-flop FIFO that buffers read data in front of the output shifter.
`timescale 1ns/1ps
module flash_if_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32
) (
	// Clock, reset and enable.
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Filling side.
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// Draining side.
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);

	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	logic [AW:0] nxt_count;
	logic in_ready_ff;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] ptr);
		bump = (ptr == AW'(DEPTH - 1)) ? '0 : ptr + AW'(1);
	endfunction

	assign push = clk_en && in_valid && in_ready_ff;
	assign pop = clk_en && out_ready && out_valid;
	assign out_valid = (count_ff != '0);
	assign out_data = mem_ff[rd_ptr_ff];
	assign in_ready = in_ready_ff;
	assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			in_ready_ff <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_ff <= bump(wr_ptr_ff);
			end
			if (pop) begin
				rd_ptr_ff <= bump(rd_ptr_ff);
			end
			count_ff <= nxt_count;
			in_ready_ff <= (nxt_count != (AW+1)'(DEPTH));
		end
	end

endmodule // flash_if_fifo

// ===== tb/flash_host.sv
// Host controller model that drives the flash port pins.
`timescale 1ns/1ps
module flash_host (
	// System clock for the released-line pattern.
	input wire logic sys_clk,
	// Device side of the port.
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe_n,
	// Pins as the device sees them.
	output logic cs_n_pin,
	output logic sck_pin,
	output logic [3:0] io_in
);
	logic [3:0] hv = 4'hf;
	logic [3:0] hen = 4'hd;
	logic flip = 1'b0;
	initial begin
		cs_n_pin = 1'b1;
		sck_pin = 1'b1;
	end
	always @(posedge sys_clk) begin
		flip <= ~flip;
	end
	// Released lines show a changing pattern instead of the last value.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			io_in[i] = !io_oe_n[i] ? io_out[i] : hen[i] ? hv[i] : flip ^ i[0];
		end
	end
	// Opens a frame with the clock idle high, just after a falling edge.
	// The offset keeps every later pin change off the sampling edge.
	task automatic start();
		@(negedge sys_clk);
		#1;
		hen = 4'hd;
		hv = 4'hf;
		cs_n_pin = 1'b0;
		#62.5;
	endtask
	// Closes a frame after a whole group has been sent.
	task automatic stop();
		#62.5 cs_n_pin = 1'b1;
		hen = 4'hd;
		#250;
	endtask
	// Moves n groups of lanes bits, most significant group first.
	task automatic xfer(input int l, input int n, input logic [31:0] v,
		output logic [31:0] r);
		r = '0;
		for (int i = n - 1; i >= 0; i--) begin
			sck_pin = 1'b0;
			for (int b = 0; b < l; b++) hv[b] = v[i * l + b];
			#62.5 sck_pin = 1'b1;
			if (l == 1) r = {r[30:0], io_in[1]};
			else r = (r << l) | 32'(io_in & 4'((1 << l) - 1));
			#62.5;
		end
	endtask
	// Keeps the clock and data lines moving while the pause line is low.
	task automatic hold();
		repeat (4) begin
			sck_pin = 1'b0;
			hv[1:0] = ~hv[1:0];
			#62.5 sck_pin = 1'b1;
			#62.5;
		end
		hv[3] = 1'b1;
		#62.5;
	endtask
endmodule // flash_host

// ===== tb/serial_flash_interface_states_bench.sv
// Self-checking bench for the flash interface state sequencing.
`timescale 1ns/1ps
module serial_flash_interface_states_bench;
	import flash_if_pkg::*;
	logic sys_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, rd_valid = 1'b0;
	logic quad_enable_bit = 1'b0, cs_n_pin, sck_pin, rd_ready, paused;
	logic cmd_strobe, cmd_reject, addr_strobe, wr_strobe, wsr_protect;
	logic write_ready;
	logic [3:0] quad_latency_field = 4'h3, io_in, io_out, io_oe_n;
	logic [7:0] rd_data = 8'h00, cmd_code, mode_bits, wr_byte;
	logic [23:0] addr;
	logic [31:0] r, evq[$];
	logic [7:0] dq[$];
	int bad_count = 0, tests_run = 0;
	flash_if_core #(.PUW_CYCLES(400), .DUAL_IO_LATENCY(2)) flash_if_core_inst (
		.sys_clk, .resetn, .clk_en, .cs_n_pin, .sck_pin, .io_in, .io_out,
		.io_oe_n, .quad_enable_bit, .quad_latency_field, .rd_data, .rd_valid,
		.rd_ready, .cmd_code, .cmd_strobe, .cmd_reject, .addr, .addr_strobe,
		.mode_bits, .wr_byte, .wr_strobe, .wsr_protect, .write_ready, .paused);
	flash_host flash_host_inst (.sys_clk, .io_out, .io_oe_n, .cs_n_pin,
		.sck_pin, .io_in);
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic chk_val(input logic [31:0] got, input logic [31:0] want);
		tests_run++;
		if (got !== want) begin
			bad_count++;
			$display("MISMATCH %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic chk_evt(input logic [31:0] got);
		chk_val(got, evq.size() ? evq.pop_front() : 32'hffffffff);
	endtask
	task automatic chk_byte(input logic [7:0] got);
		chk_val(32'(got), 32'(dq.size() ? dq.pop_front() : 8'h00));
	endtask
	always @(negedge sys_clk) begin
		if (cmd_strobe === 1'b1) chk_evt({16'h0100, cmd_code});
		if (cmd_reject === 1'b1) chk_evt(32'h02000000);
		if (addr_strobe === 1'b1) chk_evt({8'h03, addr});
		if (wr_strobe === 1'b1) chk_evt({16'h0400, wr_byte});
	end
	task automatic x(input int l, input int n, input logic [31:0] v);
		flash_host_inst.xfer(l, n, v, r);
	endtask
	task automatic pause_chk();
		flash_host_inst.hv[3] = 1'b0;
		#500;
		chk_val(io_oe_n, OE_OFF);
		chk_val(paused, 1);
		flash_host_inst.hold();
	endtask
	task automatic one(input logic [7:0] op, input logic [7:0] k, input int n);
		evq.push_back(k == 8'h02 ? 32'h02000000 : 32'({16'h0100, op}));
		flash_host_inst.start();
		x(1, 8, 32'(op));
		if (n > 0) x(1, n, $urandom);
		flash_host_inst.stop();
		chk_val(io_oe_n, OE_OFF);
	endtask
	task automatic wr(input logic [7:0] op, input int ab);
		logic [31:0] a;
		a = $urandom;
		evq.push_back({16'h0100, op});
		if (ab > 0) evq.push_back({8'h03, a[31:8]});
		evq.push_back({16'h0400, a[7:0]});
		flash_host_inst.start();
		flash_host_inst.hv[2] = 1'b0;
		x(1, 8, 32'(op));
		flash_host_inst.hv[2] = 1'b1;
		x(1, ab + 8, a);
		flash_host_inst.stop();
		chk_val(wsr_protect, 32'(op == OP_WSR));
	endtask
	task automatic rd(input logic [7:0] op, input int al, input int lat,
		input int ol, input int nb);
		logic [31:0] a;
		a = $urandom;
		evq.push_back({16'h0100, op});
		evq.push_back({8'h03, a[31:8]});
		flash_host_inst.start();
		x(1, 8, 32'(op));
		flash_host_inst.hen = al == 1 ? 4'hd : 4'hf;
		if (al == 1) x(1, 12, a >> 20);
		if (al == 1 && !quad_enable_bit) pause_chk();
		if (al == 1) x(1, 12, a >> 8);
		else x(al, 32 / al, a);
		flash_host_inst.hen = ol == 4 ? 4'h0 : 4'hc;
		x(ol, lat, 32'h0);
		for (int k = 0; k < nb; k++) begin
			x(ol, 8 / ol, 32'h0);
			chk_byte(r[7:0]);
			if (k == 0 && !quad_enable_bit) pause_chk();
		end
		if (al > 1) chk_val(mode_bits, a[7:0]);
		flash_host_inst.stop();
		chk_val(io_oe_n, OE_OFF);
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		stop_test();
	end
	initial begin
		void'($urandom(94638));
		repeat (20) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (5) @(negedge sys_clk);
		rd_valid = 1'b1;
		for (int k = 0; k < 40; k++) begin
			rd_data = 8'($urandom);
			if (rd_ready === 1'b1) dq.push_back(rd_data);
			@(negedge sys_clk);
		end
		rd_valid = 1'b0;
		chk_val(dq.size(), 32);
		chk_val(write_ready, 0);
		one(OP_WREN, 8'h02, 0);
		one(OP_QUAD_IO, 8'h02, 0);
		one(OP_READ, 8'h01, 10);
		for (int k = 0; k < 1000 && write_ready !== 1'b1; k++) begin
			@(negedge sys_clk);
		end
		chk_val(write_ready, 1);
		one(OP_WREN, 8'h01, 0);
		wr(OP_PROGRAM, 24);
		wr(OP_WSR, 0);
		rd(OP_READ, 1, 0, 1, 2);
		rd(OP_FAST, 1, 8, 1, 2);
		rd(OP_DUAL_OUT, 1, 8, 2, 2);
		rd(OP_DUAL_IO, 2, 2, 2, 2);
		@(negedge sys_clk);
		quad_enable_bit = 1'b1;
		quad_latency_field = 4'($urandom_range(1, 6));
		rd(OP_QUAD_OUT, 1, int'(quad_latency_field), 4, 2);
		rd(OP_QUAD_IO, 4, int'(quad_latency_field), 4, 2);
		rd(OP_READ, 1, 0, 1, 21);
		chk_val(evq.size(), 0);
		stop_test();
	end
endmodule // serial_flash_interface_states_bench
